/* logic/ukw_pkg.sv */
// package: constants and types of the usb wake event logic
package ukw_pkg;
  localparam int         UKW_NPORTS       = 4;
  localparam logic [7:0] ADDR_PM_CTL_OHCI = 8'h00;
  localparam logic [7:0] ADDR_PM_CTL_EHCI = 8'h04;
  localparam logic [7:0] ADDR_PM_CAP_OHCI = 8'h08;
  localparam logic [7:0] ADDR_PM_CAP_EHCI = 8'h0C;
  localparam logic [7:0] ADDR_UNLOCK      = 8'h10;
  localparam logic [7:0] ADDR_OHCI_CTL    = 8'h14;
  localparam logic [7:0] ADDR_EHCI_WAKE   = 8'h18;
  localparam logic [7:0] ADDR_IRQ_STAT    = 8'h1C;
  localparam logic [7:0] ADDR_IRQ_MASK    = 8'h20;
  localparam logic [7:0] ADDR_STATUS      = 8'h24;
  localparam int         PS_LSB           = 0;
  localparam int         WOE_BIT          = 8;
  localparam int         WSF_BIT          = 15;
  localparam int         CAP_AUX_LSB      = 6;
  localparam int         CAP_WAKE_LSB     = 11;
  localparam int         CAP_D3C_IDX      = 4;
  localparam int         UNLOCK_BIT       = 0;
  localparam int         OC_RWE           = 0;
  localparam int         OC_DEVICE_REMOTE_WAKE_ENABLE          = 1;
  localparam int         OC_HUB_STATUS_CHANGE_INT_ENABLE          = 2;
  localparam int         OC_RD            = 3;
  localparam int         EN_CONN_LSB      = 0;
  localparam int         EN_DISC_LSB      = 8;
  localparam int         EN_OC_LSB        = 16;
  localparam int         IRQ_W            = 3;
  localparam logic [4:0] CAP_WAKE_RST     = 5'h0F;
  localparam logic [2:0] CAP_AUX_RST      = 3'h0;

  typedef enum logic [1:0] {PS_D0 = 2'h0, PS_D1 = 2'h1, PS_D3 = 2'h3, PS_D2 = 2'h2} ukw_pstate_type;
  typedef enum logic [1:0] {BUS_B0 = 2'h0, BUS_B1 = 2'h1, BUS_B3 = 2'h3, BUS_B2 = 2'h2} ukw_bus_type;

  typedef struct packed {
    logic connect;
    logic disconnect;
    logic remote_wake;
    logic overcurrent;
    logic owner_ehci;
    logic suspended;
  } ukw_port_ev_type;

  typedef struct packed {
    logic connect;
    logic disconnect;
    logic remote_wake;
    logic overcurrent;
  } ukw_port_st_type;

  typedef struct packed {
    ukw_pstate_type ps;
    logic           woe;
    logic           wsf;
    logic [4:0]     cap_wake;
    logic [2:0]     cap_aux;
  } ukw_core_type;

  typedef struct packed {
    ukw_port_ev_type [UKW_NPORTS-1:0] ev_s1;
    ukw_port_ev_type [UKW_NPORTS-1:0] ev_s2;
    logic                             main_s1;
    logic                             main_s2;
    logic                             main_prev;
    logic [1:0]                       bus_s1;
    logic [1:0]                       bus_s2;
    ukw_core_type [1:0]               core;
    logic                             unlock;
    logic [3:0]                       ohci_ctl;
    logic [UKW_NPORTS-1:0]            conn_en;
    logic [UKW_NPORTS-1:0]            disc_en;
    logic [UKW_NPORTS-1:0]            oc_en;
    logic [IRQ_W-1:0]                 irq_stat;
    logic [IRQ_W-1:0]                 irq_mask;
    logic [31:0]                      rdata;
    logic                             pm_out;
    logic                             irq_out;
  } ukw_state_type;

  localparam ukw_core_type UKW_CORE_RST = '{ps: PS_D0, woe: 1'b0, wsf: 1'b0,
                                            cap_wake: CAP_WAKE_RST, cap_aux: CAP_AUX_RST};
  localparam ukw_state_type UKW_STATE_RST = '{core: '{default: UKW_CORE_RST}, default: '0};
endpackage

/* logic/ukw_port_wake.sv */
// leaf: wake and interrupt qualification of one root port
`timescale 1ns/1ps
module ukw_port_wake
  import ukw_pkg::*;
(
  input  wire logic            ref_clk,
  input  wire logic            srst,
  input  wire ukw_port_ev_type ev,
  input  wire logic            remote_wake_enable,
  input  wire logic            device_remote_wake_enable,
  input  wire logic            hub_status_change_int_enable,
  input  wire logic            resume_int_enable,
  input  wire logic            wake_on_connect_enable,
  input  wire logic            wake_on_disconnect_enable,
  input  wire logic            wake_on_overcurrent_enable,
  input  wire logic            in_d0,
  output logic                 ohci_wake,
  output logic                 ehci_wake,
  output logic                 ohci_int
);
  ukw_port_st_type st_reg;
  ukw_port_st_type st_next;
  logic            rise_conn;
  logic            rise_disc;
  logic            rise_rw;
  logic            rise_oc;
  logic            legacy;

  ////////////////////////////////////////////////////////////////////////
  // edge detection on the synchronised port levels
  always_comb begin
    st_next             = st_reg;
    st_next.connect     = ev.connect;
    st_next.disconnect  = ev.disconnect;
    st_next.remote_wake = ev.remote_wake;
    st_next.overcurrent = ev.overcurrent;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rise_conn = ev.connect & ~st_reg.connect;
  assign rise_disc = ev.disconnect & ~st_reg.disconnect;
  assign rise_rw   = ev.remote_wake & ~st_reg.remote_wake;
  assign rise_oc   = ev.overcurrent & ~st_reg.overcurrent;
  assign legacy    = ~ev.owner_ehci & ev.suspended;

  ////////////////////////////////////////////////////////////////////////
  // qualification
  assign ohci_wake = legacy & remote_wake_enable &
                     (rise_rw | ((rise_conn | rise_disc) & device_remote_wake_enable));
  assign ehci_wake = ev.owner_ehci & ((rise_oc & wake_on_overcurrent_enable) |
                     (ev.suspended & (rise_rw | (rise_conn & wake_on_connect_enable) |
                     (rise_disc & wake_on_disconnect_enable))));
  assign ohci_int  = in_d0 & legacy & (rise_conn | rise_disc) &
                     (hub_status_change_int_enable | (device_remote_wake_enable & resume_int_enable));

  ////////////////////////////////////////////////////////////////////////
  // checks
  property p_legacy_conn;
    @(posedge ref_clk) disable iff (srst)
    (ohci_wake && !rise_rw) |-> (remote_wake_enable && device_remote_wake_enable && !ev.owner_ehci);
  endproperty
  a_legacy_conn: assert property (p_legacy_conn) else $error("legacy connect wake without enables");

  property p_legacy_rw;
    @(posedge ref_clk) disable iff (srst)
    (rise_rw && legacy && remote_wake_enable) |-> ohci_wake;
  endproperty
  a_legacy_rw: assert property (p_legacy_rw) else $error("legacy remote wake lost");

  property p_ehci_wake;
    @(posedge ref_clk) disable iff (srst)
    (ehci_wake && !rise_rw) |-> ((rise_conn && wake_on_connect_enable) ||
      (rise_disc && wake_on_disconnect_enable) || (rise_oc && wake_on_overcurrent_enable));
  endproperty
  a_ehci_wake: assert property (p_ehci_wake) else $error("port wake without its enable");

  property p_d0_int;
    @(posedge ref_clk) disable iff (srst)
    ohci_int |-> (in_d0 && (hub_status_change_int_enable ||
      (device_remote_wake_enable && resume_int_enable)));
  endproperty
  a_d0_int: assert property (p_d0_int) else $error("connect interrupt without enable");
endmodule

/* logic/ukw_wake_logic.sv */
// top: usb host wake event logic with its register port
//
// Our own choices: the address map and the strobed register port.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
module ukw_wake_logic
  import ukw_pkg::*;
(
  input  wire logic                            ref_clk,
  input  wire logic                            srst,
  input  wire logic [7:0]                      reg_addr,
  input  wire logic [31:0]                     reg_wdata,
  input  wire logic                            reg_wr,
  input  wire logic                            reg_rd,
  output logic [31:0]                          reg_rdata,
  input  wire logic                            main_domain_reset,
  input  wire logic [1:0]                      pci_bus_state,
  input  wire ukw_port_ev_type [UKW_NPORTS-1:0] port_ev,
  input  wire logic                            rom_load,
  input  wire logic [7:0]                      rom_cap,
  output logic                                 pm_event_out,
  output logic                                 interrupt_out
);
  ////////////////////////////////////////////////////////////////////////
  // state and helpers
  ukw_state_type         r_reg;
  ukw_state_type         r_next;
  logic [UKW_NPORTS-1:0] ohci_wake;
  logic [UKW_NPORTS-1:0] ehci_wake;
  logic [UKW_NPORTS-1:0] ohci_int;
  logic                  main_ok;
  logic                  in_d3;
  logic                  in_d0;
  logic                  wr_ok;
  logic                  rd_ok;
  logic                  restrict_int;
  logic                  ctl0_wr;
  logic                  ctl1_wr;
  logic                  cap0_wr;
  logic                  cap1_wr;
  logic [1:0]            wake_set;
  logic [IRQ_W-1:0]      irq_set;
  logic [IRQ_W-1:0]      irq_clr;
  logic [31:0]           rd_mux;

  function automatic ukw_core_type core_upd(
    input ukw_core_type c,
    input logic         ctl_wr,
    input logic         cap_wr,
    input logic         wake,
    input logic [31:0]  d,
    input logic         load,
    input logic [7:0]   rom
  );
    ukw_core_type n;
    n = c;
    if (ctl_wr) begin
      n.ps  = ukw_pstate_type'(d[PS_LSB +: 2]);
      n.woe = d[WOE_BIT];
    end
    if (load) begin
      n.cap_wake = rom[7:3];
      n.cap_aux  = rom[2:0];
    end else if (cap_wr) begin
      n.cap_wake = d[CAP_WAKE_LSB +: 5];
      n.cap_aux  = d[CAP_AUX_LSB +: 3];
    end
    n.wsf = (c.wsf & ~(ctl_wr & d[WSF_BIT])) | wake;
    return n;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // decode
  assign main_ok = r_reg.main_s2;
  assign in_d3   = (r_reg.core[0].ps == PS_D3);
  assign in_d0   = (r_reg.core[0].ps == PS_D0);
  assign wr_ok   = reg_wr & main_ok;
  assign rd_ok   = reg_rd & main_ok;
  assign ctl0_wr = wr_ok & (reg_addr == ADDR_PM_CTL_OHCI);
  assign ctl1_wr = wr_ok & (reg_addr == ADDR_PM_CTL_EHCI);
  assign cap0_wr = wr_ok & r_reg.unlock & (reg_addr == ADDR_PM_CAP_OHCI);
  assign cap1_wr = wr_ok & r_reg.unlock & (reg_addr == ADDR_PM_CAP_EHCI);
  assign wake_set = {|ehci_wake, |ohci_wake};
  assign irq_set  = {wake_set, |ohci_int};
  assign irq_clr  = (wr_ok && reg_addr == ADDR_IRQ_STAT) ? reg_wdata[IRQ_W-1:0] : '0;

  // only wake signalling while the bus is off (B3), in B1 at D1, or in B1/B2 at D2/D3
  assign restrict_int = (r_reg.bus_s2 == BUS_B3) ||
                        (r_reg.core[0].ps == PS_D1 && r_reg.bus_s2 == BUS_B1) ||
                        ((r_reg.core[0].ps == PS_D2 || in_d3) &&
                         (r_reg.bus_s2 == BUS_B1 || r_reg.bus_s2 == BUS_B2));

  ////////////////////////////////////////////////////////////////////////
  // per-port qualifiers
  genvar p;
  generate
    for (p = 0; p < UKW_NPORTS; p++) begin : g_port
      ukw_port_wake u_port (
        .ref_clk                      (ref_clk),
        .srst                         (srst),
        .ev                           (r_reg.ev_s2[p]),
        .remote_wake_enable           (r_reg.ohci_ctl[OC_RWE]),
        .device_remote_wake_enable    (r_reg.ohci_ctl[OC_DEVICE_REMOTE_WAKE_ENABLE]),
        .hub_status_change_int_enable (r_reg.ohci_ctl[OC_HUB_STATUS_CHANGE_INT_ENABLE]),
        .resume_int_enable            (r_reg.ohci_ctl[OC_RD]),
        .wake_on_connect_enable       (r_reg.conn_en[p]),
        .wake_on_disconnect_enable    (r_reg.disc_en[p]),
        .wake_on_overcurrent_enable   (r_reg.oc_en[p]),
        .in_d0                        (in_d0),
        .ohci_wake                    (ohci_wake[p]),
        .ehci_wake                    (ehci_wake[p]),
        .ohci_int                     (ohci_int[p])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // read mux
  always_comb begin
    if (reg_addr == ADDR_PM_CTL_OHCI) begin
      rd_mux = {16'h0000, r_reg.core[0].wsf, 6'h00, r_reg.core[0].woe, 6'h00, r_reg.core[0].ps};
    end else if (reg_addr == ADDR_PM_CTL_EHCI) begin
      rd_mux = {16'h0000, r_reg.core[1].wsf, 6'h00, r_reg.core[1].woe, 6'h00, r_reg.core[1].ps};
    end else if (reg_addr == ADDR_PM_CAP_OHCI) begin
      rd_mux = {16'h0000, r_reg.core[0].cap_wake, 2'h0, r_reg.core[0].cap_aux, 6'h00};
    end else if (reg_addr == ADDR_PM_CAP_EHCI) begin
      rd_mux = {16'h0000, r_reg.core[1].cap_wake, 2'h0, r_reg.core[1].cap_aux, 6'h00};
    end else if (reg_addr == ADDR_UNLOCK) begin
      rd_mux = {31'h00000000, r_reg.unlock};
    end else if (reg_addr == ADDR_OHCI_CTL) begin
      rd_mux = {28'h0000000, r_reg.ohci_ctl};
    end else if (reg_addr == ADDR_EHCI_WAKE) begin
      rd_mux = {8'h00, 8'(r_reg.oc_en), 8'(r_reg.disc_en), 8'(r_reg.conn_en)};
    end else if (reg_addr == ADDR_IRQ_STAT) begin
      rd_mux = {29'h00000000, r_reg.irq_stat};
    end else if (reg_addr == ADDR_IRQ_MASK) begin
      rd_mux = {29'h00000000, r_reg.irq_mask};
    end else if (reg_addr == ADDR_STATUS) begin
      rd_mux = {28'h0000000, r_reg.pm_out, r_reg.bus_s2, r_reg.main_s2};
    end else begin
      rd_mux = 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    r_next = r_reg;
    // sticky wake flags, set beats clear
    r_next.core[0] = core_upd(r_reg.core[0], ctl0_wr, cap0_wr, wake_set[0],
                              reg_wdata, rom_load, rom_cap);
    r_next.core[1] = core_upd(r_reg.core[1], ctl1_wr, cap1_wr, wake_set[1],
                              reg_wdata, rom_load, rom_cap);
    // main reset rising edge brings D3 back to D0
    if (main_ok && !r_reg.main_prev && in_d3) begin
      r_next.core[0].ps = PS_D0;
      r_next.core[1].ps = PS_D0;
    end
    if (wr_ok) begin
      if (reg_addr == ADDR_UNLOCK) begin
        r_next.unlock = reg_wdata[UNLOCK_BIT];
      end else if (reg_addr == ADDR_OHCI_CTL) begin
        r_next.ohci_ctl = reg_wdata[OC_RD:OC_RWE];
      end else if (reg_addr == ADDR_EHCI_WAKE) begin
        r_next.conn_en = reg_wdata[EN_CONN_LSB +: UKW_NPORTS];
        r_next.disc_en = reg_wdata[EN_DISC_LSB +: UKW_NPORTS];
        r_next.oc_en   = reg_wdata[EN_OC_LSB +: UKW_NPORTS];
      end else if (reg_addr == ADDR_IRQ_MASK) begin
        r_next.irq_mask = reg_wdata[IRQ_W-1:0];
      end
    end
    r_next.irq_stat = (r_reg.irq_stat & ~irq_clr) | irq_set;
    // event output: flag gated by its enable, no bus clock involved
    r_next.pm_out = (r_reg.core[0].wsf & r_reg.core[0].woe) |
                    (r_reg.core[1].wsf & r_reg.core[1].woe);
    r_next.irq_out = (|(r_reg.irq_stat & r_reg.irq_mask)) & ~restrict_int;
    r_next.rdata = rd_ok ? rd_mux : 32'h00000000;
    // main reset low outside D3 clears the device, D3 retains
    if (!main_ok && !in_d3) begin
      r_next = UKW_STATE_RST;
    end
    // synchronisers always run
    r_next.ev_s1     = port_ev;
    r_next.ev_s2     = r_reg.ev_s1;
    r_next.main_s1   = main_domain_reset;
    r_next.main_s2   = r_reg.main_s1;
    r_next.main_prev = r_reg.main_s2;
    r_next.bus_s1    = pci_bus_state;
    r_next.bus_s2    = r_reg.bus_s1;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      r_reg <= UKW_STATE_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  assign reg_rdata     = r_reg.rdata;
  assign pm_event_out  = r_reg.pm_out;
  assign interrupt_out = r_reg.irq_out;

  ////////////////////////////////////////////////////////////////////////
  // checks
  property p_out_or;
    @(posedge ref_clk) disable iff (srst)
    (((r_reg.core[0].wsf && r_reg.core[0].woe) || (r_reg.core[1].wsf && r_reg.core[1].woe)) &&
     (main_ok || in_d3)) |=> pm_event_out;
  endproperty
  a_out_or: assert property (p_out_or) else $error("event output missing");

  property p_out_gate;
    @(posedge ref_clk) disable iff (srst)
    (!(r_reg.core[0].wsf && r_reg.core[0].woe) && !(r_reg.core[1].wsf && r_reg.core[1].woe))
    |=> !pm_event_out;
  endproperty
  a_out_gate: assert property (p_out_gate) else $error("event output without enabled flag");

  property p_sticky;
    @(posedge ref_clk) disable iff (srst)
    (r_reg.core[0].wsf && !(ctl0_wr && reg_wdata[WSF_BIT]) && (main_ok || in_d3))
    |=> r_reg.core[0].wsf;
  endproperty
  a_sticky: assert property (p_sticky) else $error("wake flag dropped");

  property p_cap_rst;
    @(posedge ref_clk) disable iff (srst)
    $fell(srst) |-> (!r_reg.core[0].cap_wake[CAP_D3C_IDX] && !r_reg.core[1].cap_wake[CAP_D3C_IDX]);
  endproperty
  a_cap_rst: assert property (p_cap_rst) else $error("cold wake advertised at reset");

  property p_cap_lock;
    @(posedge ref_clk) disable iff (srst)
    (reg_wr && main_ok && !r_reg.unlock && !rom_load && reg_addr == ADDR_PM_CAP_OHCI)
    |=> ($stable(r_reg.core[0].cap_wake) && $stable(r_reg.core[0].cap_aux));
  endproperty
  a_cap_lock: assert property (p_cap_lock) else $error("locked capability changed");

  property p_retain;
    @(posedge ref_clk) disable iff (srst)
    (!main_ok && in_d3 && !rom_load) |=> (r_reg.core[0].ps == PS_D3 &&
      $stable(r_reg.core[0].cap_wake) && $stable(r_reg.core[0].woe) && $stable(r_reg.conn_en));
  endproperty
  a_retain: assert property (p_retain) else $error("registers lost in D3");

  property p_full_rst;
    @(posedge ref_clk) disable iff (srst)
    (!main_ok && !in_d3) |=> (r_reg.core[0].ps == PS_D0 && !r_reg.unlock &&
      r_reg.irq_mask == '0 && !pm_event_out ##1 !interrupt_out);
  endproperty
  a_full_rst: assert property (p_full_rst) else $error("main reset did not clear");

  property p_bus_wr;
    @(posedge ref_clk) disable iff (srst)
    (reg_wr && !main_ok && in_d3) |=> ($stable(r_reg.ohci_ctl) && $stable(r_reg.irq_mask));
  endproperty
  a_bus_wr: assert property (p_bus_wr) else $error("write taken while bus gated");

  property p_bus_rd;
    @(posedge ref_clk) disable iff (srst)
    (reg_rd && !main_ok) |=> (reg_rdata == 32'h00000000);
  endproperty
  a_bus_rd: assert property (p_bus_rd) else $error("read answered while bus gated");

  property p_wake_d0;
    @(posedge ref_clk) disable iff (srst)
    (main_ok && !r_reg.main_prev && in_d3) |=>
      (r_reg.core[0].ps == PS_D0 && r_reg.core[1].ps == PS_D0);
  endproperty
  a_wake_d0: assert property (p_wake_d0) else $error("no D0 after main reset rise");

  property p_restrict;
    @(posedge ref_clk) disable iff (srst)
    restrict_int |=> !interrupt_out;
  endproperty
  a_restrict: assert property (p_restrict) else $error("interrupt in restricted bus state");

  property p_sticky_ehci;
    @(posedge ref_clk) disable iff (srst)
    (r_reg.core[1].wsf && !(ctl1_wr && reg_wdata[WSF_BIT]) && (main_ok || in_d3)) |=> r_reg.core[1].wsf;
  endproperty
  a_sticky_ehci: assert property (p_sticky_ehci) else $error("modern wake flag dropped");

  property p_flag_ohci;
    @(posedge ref_clk) disable iff (srst)
    (wake_set[0] && (main_ok || in_d3)) |=> r_reg.core[0].wsf;
  endproperty
  a_flag_ohci: assert property (p_flag_ohci) else $error("legacy wake not flagged");

  property p_flag_ehci;
    @(posedge ref_clk) disable iff (srst)
    (wake_set[1] && (main_ok || in_d3)) |=> r_reg.core[1].wsf;
  endproperty
  a_flag_ehci: assert property (p_flag_ehci) else $error("modern wake not flagged");

  property p_irq_out;
    @(posedge ref_clk) disable iff (srst)
    ((|(r_reg.irq_stat & r_reg.irq_mask)) && !restrict_int && (main_ok || in_d3)) |=> interrupt_out;
  endproperty
  a_irq_out: assert property (p_irq_out) else $error("enabled interrupt missing");

  property p_irq_legacy;
    @(posedge ref_clk) disable iff (srst)
    ((|ohci_int) && (main_ok || in_d3)) |=> r_reg.irq_stat[0];
  endproperty
  a_irq_legacy: assert property (p_irq_legacy) else $error("legacy connect interrupt not latched");

  property p_rd_idle;
    @(posedge ref_clk) disable iff (srst)
    !rd_ok |=> (reg_rdata == 32'h00000000);
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside answer cycle");

  property p_d3_out;
    @(posedge ref_clk) disable iff (srst)
    (!main_ok && in_d3 && r_reg.core[0].wsf && r_reg.core[0].woe) |=> pm_event_out;
  endproperty
  a_d3_out: assert property (p_d3_out) else $error("event output lost without bus");

  property p_d3_keep;
    @(posedge ref_clk) disable iff (srst)
    (!main_ok && in_d3) |=> (r_reg.core[1].ps == PS_D3 && $stable(r_reg.ohci_ctl) && $stable(r_reg.irq_mask));
  endproperty
  a_d3_keep: assert property (p_d3_keep) else $error("control lost in D3");
endmodule

/* tb/ukw_host_model.sv */
// far side model: chipset that sequences main reset and bus state
`timescale 1ns/1ps
module ukw_host_model
  import ukw_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic sleep,
  output logic      main_domain_reset,
  output logic [1:0] pci_bus_state
);
  logic [3:0] wait_cnt;
  initial begin
    main_domain_reset = 1'b1;
    pci_bus_state = BUS_B0;
    wait_cnt = 4'hF;
  end
  // sleep request: bus powers off and main reset falls together
  always @(posedge ref_clk) begin
    if (sleep) begin
      pci_bus_state <= BUS_B3;
      main_domain_reset <= 1'b0;
      wait_cnt <= 4'h0;
    end else begin
      pci_bus_state <= BUS_B0;
      if (wait_cnt != 4'hF) begin
        wait_cnt <= wait_cnt + 4'h1;
      end else begin
        main_domain_reset <= 1'b1; // only once the bus is back in B0
      end
    end
  end
endmodule

/* tb/tb_ukw_wake_logic.sv */
// testbench: register port, wake flags, event output and reset sequencing
`timescale 1ns/1ps
module tb_ukw_wake_logic
  import ukw_pkg::*;
;
  logic                             ref_clk = 1'b0;
  logic                             srst = 1'b1;
  logic [7:0]                       reg_addr = 8'h00;
  logic [31:0]                      reg_wdata = 32'h0;
  logic                             reg_wr = 1'b0;
  logic                             reg_rd = 1'b0;
  logic [31:0]                      reg_rdata;
  logic                             main_domain_reset;
  logic [1:0]                       pci_bus_state;
  ukw_port_ev_type [UKW_NPORTS-1:0] port_ev;
  logic                             rom_load = 1'b0;
  logic                             sleep = 1'b0;
  logic                             pm_event_out;
  logic                             interrupt_out;
  logic [31:0]                      exp_q[$];
  logic                             rd_pend = 1'b0;
  logic [31:0]                      rv;
  logic [5:0]                       evs[3] = '{6'h20, 6'h10, 6'h04};
  int                               lsb[3] = '{EN_CONN_LSB, EN_DISC_LSB, EN_OC_LSB};
  int                               fail_count = 0;
  int                               n_tests = 0;

  always #50 ref_clk = ~ref_clk;

  ukw_host_model u_ukw_host_model (.ref_clk(ref_clk), .sleep(sleep), .main_domain_reset(main_domain_reset),
    .pci_bus_state(pci_bus_state));
  ukw_wake_logic u_ukw_wake_logic (.ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .main_domain_reset(main_domain_reset),
    .pci_bus_state(pci_bus_state), .port_ev(port_ev), .rom_load(rom_load), .rom_cap(rv[7:0]),
    .pm_event_out(pm_event_out), .interrupt_out(interrupt_out));

  ////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, s, e);
    end
  endtask
  task end_of_test;
    $display("compares %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
  endtask
  task pulse(input int p, input logic [5:0] e);
    @(posedge ref_clk);
    port_ev[p] <= ukw_port_ev_type'(port_ev[p] | e);
    repeat (3) @(posedge ref_clk);
    port_ev[p] <= ukw_port_ev_type'(port_ev[p] & ~e);
    repeat (5) @(posedge ref_clk);
  endtask

  // read data stand one cycle after the strobe: compare with oldest note
  always @(posedge ref_clk) begin
    if (rd_pend) chk(reg_rdata, exp_q.pop_front());
    rd_pend <= reg_rd;
  end

  initial begin
    #(100 * 20000);
    fail_count++;
    end_of_test;
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    for (int i = 0; i < UKW_NPORTS; i++) port_ev[i] = ukw_port_ev_type'(i[0] ? 6'h03 : 6'h01);
    rv = $urandom(32'h19d83252);
    repeat (4) @(posedge ref_clk);
    srst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    // capability field: reset value, lock, unlock
    rd(ADDR_PM_CAP_OHCI, 32'h7800);
    wr(ADDR_PM_CAP_OHCI, 32'hFFFF);
    rd(ADDR_PM_CAP_OHCI, 32'h7800);
    rd(8'h30, 32'h0);
    wr(ADDR_UNLOCK, 32'h1);
    rv = $urandom;
    wr(ADDR_PM_CAP_OHCI, rv);
    wr(ADDR_PM_CAP_EHCI, rv);
    rd(ADDR_PM_CAP_EHCI, rv & 32'hF9C0);
    wr(ADDR_UNLOCK, 32'h0);
    @(posedge ref_clk);
    rom_load <= 1'b1;
    @(posedge ref_clk);
    rom_load <= 1'b0;
    rd(ADDR_PM_CAP_OHCI, {16'h0000, rv[7:3], 2'h0, rv[2:0], 6'h00});
    $display("capability test done");
    // legacy port wake qualification and sticky flag
    wr(ADDR_OHCI_CTL, 32'h1);
    wr(ADDR_PM_CTL_OHCI, 32'h100);
    pulse(0, 6'h20);
    rd(ADDR_PM_CTL_OHCI, 32'h100);
    pulse(0, 6'h08);
    rd(ADDR_PM_CTL_OHCI, 32'h8100);
    rd(ADDR_STATUS, 32'h9);
    wr(ADDR_PM_CTL_OHCI, 32'h8100);
    rd(ADDR_STATUS, 32'h1);
    wr(ADDR_OHCI_CTL, 32'h3);
    pulse(0, 6'h10);
    rd(ADDR_PM_CTL_OHCI, 32'h8100);
    wr(ADDR_PM_CTL_OHCI, 32'h8100);
    $display("legacy wake test done");
    // interrupt: status, mask, clear
    rd(ADDR_IRQ_STAT, 32'h2);
    wr(ADDR_IRQ_STAT, 32'h7);
    wr(ADDR_IRQ_MASK, 32'h1);
    wr(ADDR_OHCI_CTL, 32'h5);
    pulse(0, 6'h20);
    chk({31'h0, interrupt_out}, 32'h1);
    wr(ADDR_IRQ_MASK, 32'h0);
    repeat (2) @(posedge ref_clk);
    chk({31'h0, interrupt_out}, 32'h0);
    wr(ADDR_IRQ_STAT, 32'h1);
    wr(ADDR_IRQ_MASK, 32'h1);
    repeat (2) @(posedge ref_clk);
    chk({31'h0, interrupt_out}, 32'h0);
    $display("interrupt test done");
    // modern port: connect, disconnect and overcurrent each need their own enable
    wr(ADDR_PM_CTL_EHCI, 32'h100);
    for (int k = 0; k < 3; k++) begin
      wr(ADDR_EHCI_WAKE, 32'h0);
      pulse(1, evs[k]);
      rd(ADDR_PM_CTL_EHCI, 32'h100);
      wr(ADDR_EHCI_WAKE, 32'h2 << lsb[k]);
      pulse(1, evs[k]);
      rd(ADDR_PM_CTL_EHCI, 32'h8100);
      wr(ADDR_PM_CTL_EHCI, 32'h8100);
    end
    // pending flag reaches output only once enabled
    wr(ADDR_PM_CTL_EHCI, 32'h0);
    wr(ADDR_EHCI_WAKE, 32'h2);
    pulse(1, 6'h20);
    rd(ADDR_STATUS, 32'h1);
    wr(ADDR_PM_CTL_EHCI, 32'h100);
    rd(ADDR_STATUS, 32'h9);
    wr(ADDR_PM_CTL_EHCI, 32'h8100);
    $display("modern wake test done");
    // cold-off wake: retention, output without bus, return to D0
    wr(ADDR_OHCI_CTL, 32'h1);
    wr(ADDR_PM_CTL_OHCI, 32'h103);
    wr(ADDR_PM_CTL_EHCI, 32'h103);
    sleep <= 1'b1;
    repeat (6) @(posedge ref_clk);
    wr(ADDR_OHCI_CTL, 32'h0);
    pulse(0, 6'h08);
    chk({31'h0, pm_event_out}, 32'h1);
    sleep <= 1'b0;
    repeat (22) @(posedge ref_clk);
    rd(ADDR_PM_CTL_OHCI, 32'h8100);
    rd(ADDR_PM_CTL_EHCI, 32'h100);
    wr(ADDR_PM_CTL_OHCI, 32'h8100);
    // main reset outside D3: bus gated, then everything reset
    sleep <= 1'b1;
    repeat (6) @(posedge ref_clk);
    rd(ADDR_OHCI_CTL, 32'h0);
    sleep <= 1'b0;
    repeat (22) @(posedge ref_clk);
    rd(ADDR_OHCI_CTL, 32'h0);
    rd(ADDR_PM_CAP_OHCI, 32'h7800);
    repeat (3) @(posedge ref_clk);
    $display("power state test done");
    end_of_test;
  end
endmodule
